// ===== core/pbm_defs.vh
// constants for the port b low pin function selector
`ifndef PBM_DEFS_VH
`define PBM_DEFS_VH

// register word indices on the axi4-lite bus (byte address / 4)
`define PBM_OFS_CTRL     4'h0
`define PBM_OFS_DIR      4'h1
`define PBM_OFS_PULLUP   4'h2
`define PBM_OFS_TMODE6   4'h3
`define PBM_OFS_IOCTL6   4'h4
`define PBM_OFS_TCTRL6   4'h5
`define PBM_OFS_TPRESC   4'h6
`define PBM_OFS_PDATA    4'h7
`define PBM_OFS_STATUS   4'h8
// word index msb and byte-address low bits dropped
`define PBM_IDX_MSB      5
`define PBM_IDX_LSB      2

// reset values
`define PBM_RST_CTRL     1'h0
`define PBM_RST_DIR      8'h00
`define PBM_RST_PULLUP   8'h00
`define PBM_RST_TMODE6   6'h00
`define PBM_RST_IOCTL6   16'h0000
`define PBM_RST_TCTRL6   6'h00
`define PBM_RST_TPRESC   17'h0_0000
`define PBM_RST_PDATA    4'h0

// field positions
`define PBM_F_MD         3:0
`define PBM_F_BFA        4
`define PBM_F_BFB        5
`define PBM_F_PSC        2:0
`define PBM_F_CCLR       5:3
`define PBM_F_PSC7       2:0
`define PBM_F_PSC8       5:3
`define PBM_F_PSC9       8:6
`define PBM_F_PSC10      11:9
`define PBM_F_PSC11      14:12
`define PBM_F_PHC7       15
`define PBM_F_PHC11      16

// operating modes
`define PBM_MODE_1       3'h1
`define PBM_MODE_2       3'h2
`define PBM_MODE_4       3'h4
`define PBM_MODE_7       3'h7

// timer mode field codes
`define PBM_MD_NORMAL    4'h0
`define PBM_MD_PWM1      4'h2
`define PBM_MD_PWM2      4'h3

// io control field pieces
`define PBM_IO_EDGE_NONE 2'h0
`define PBM_IO_CAPTURE   2'h2

// prescaler codes that pick the external clock pins
`define PBM_PSC_CLK_E    3'h4
`define PBM_PSC_CLK_F    3'h5

// counter clear codes naming each pin's own compare register
`define PBM_CCLR_A       3'h1
`define PBM_CCLR_B       3'h2
`define PBM_CCLR_C       3'h5
`define PBM_CCLR_D       3'h6

// pin function codes
`define PBM_FN_INPUT     2'h0
`define PBM_FN_ADDR      2'h1
`define PBM_FN_PORT      2'h2
`define PBM_FN_TIMER     2'h3

// axi responses
`define PBM_RESP_OKAY    2'h0
`define PBM_RESP_SLVERR  2'h2
`define PBM_ZERO32       32'h0000_0000

`endif

// ===== core/pbm_pin_sel.v
// per-pin function decode for one shared port b / address / timer pin
`timescale 1ns/1ns
`include "pbm_defs.vh"

module pbm_pin_sel #(
    parameter       HAS_PWM1 = 1,
    parameter [2:0] CCLR_OWN = `PBM_CCLR_A
) (
    // mode and port settings
    input  wire       i_mode_addr,
    input  wire       i_mode_exp,
    input  wire       i_mode_single,
    input  wire       i_dir,
    // channel 6 settings
    input  wire [3:0] i_md,
    input  wire [3:0] i_io,
    input  wire [2:0] i_cclr,
    input  wire       i_pwm1_block,
    // decoded function
    output reg  [1:0] o_func,
    output wire       o_capture,
    output wire       o_pwm1
);
    wire io_edge = (i_io[1:0] != `PBM_IO_EDGE_NONE);

    // output compare only for 0001..0011 and 0101..0111
    wire oc_on   = (i_md == `PBM_MD_NORMAL) && !i_io[3] && io_edge;
    // pwm mode 1 only on pins a and c, and only if not blocked
    assign o_pwm1 = (HAS_PWM1 != 0) && (i_md == `PBM_MD_PWM1) && io_edge
                    && !i_pwm1_block;
    // pwm mode 2 is lost when this pin's own compare clears the counter
    wire pwm2_on = (i_md == `PBM_MD_PWM2) && io_edge && (i_cclr != CCLR_OWN);
    wire tmr_on  = oc_on || o_pwm1 || pwm2_on;

    // capture path does not override the direction bit
    assign o_capture = (i_md == `PBM_MD_NORMAL)
                       && (i_io[3:2] == `PBM_IO_CAPTURE);

    // mode priority: address modes, expanded modes, single-chip
    always @* begin
        o_func = `PBM_FN_INPUT;
        if (i_mode_addr) begin
            o_func = `PBM_FN_ADDR;
        end else if (i_mode_exp) begin
            o_func = i_dir ? `PBM_FN_ADDR : `PBM_FN_INPUT;
        end else if (i_mode_single) begin
            if (tmr_on) begin
                o_func = `PBM_FN_TIMER;
            end else begin
                o_func = i_dir ? `PBM_FN_PORT : `PBM_FN_INPUT;
            end
        end
    end
endmodule // pbm_pin_sel

// ===== core/pbm_top.v
// port b low pin function selector with axi4-lite control registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "pbm_defs.vh"

// Summary of operation
// - pins 3..0 carry address bits 11..8 or timer 6 pins d..a.
// - modes 1,2 always address; modes 4,7 expanded: direction picks input or address.
// - mode 7 single-chip: timer output wins, else direction picks port in/out.
// - normal mode: compare output for io 0001-0011, 0101-0111, else none.
// - pwm1 mode: pins a,c drive pwm1 unless io xx00; pins b,d lose timer.
// - pwm2 mode drives pin unless io xx00 or counter clear names its own register.
// - either buffer mode bit disables pwm1 on pin c.
// - normal mode with io 10xx routes pin to capture; direction still rules port.
// - pin 3 feeds external clock f when any prescaler of channels 6-8 is 101.
// - pin 3 feeds external clock f in phase counting on channel 7 or 11.
// - pin 2 feeds external clock e when any prescaler of channels 6-11 is 100.
// - pin 2 feeds external clock e in phase counting on channel 7 or 11.
// - pull-ups work only in modes 4 and 7.
// - one pull-up enable bit per port b pin.
// - modes 4,7: pull-up on when direction 0, enable 1 and the low pin is not a timer output.
// - modes 1,2: all pull-ups off in every state.
// - modes 4,7: pull-up only in input port state with enable set.
module pbm_top (
    // clock, reset, enable
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_ce,
    // axi4-lite write address and data
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [31:0] i_awaddr,
    input  wire [2:0]  i_awprot,
    input  wire        i_wvalid,
    output wire        o_wready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    // axi4-lite write response
    output wire        o_bvalid,
    input  wire        i_bready,
    output wire [1:0]  o_bresp,
    // axi4-lite read
    input  wire        i_arvalid,
    output wire        o_arready,
    input  wire [31:0] i_araddr,
    input  wire [2:0]  i_arprot,
    output wire        o_rvalid,
    input  wire        i_rready,
    output wire [31:0] o_rdata,
    output wire [1:0]  o_rresp,
    // chip state
    input  wire [2:0]  i_op_mode,
    input  wire        i_hw_standby,
    // sources for the low pins
    input  wire [3:0]  i_addr_hi,
    input  wire [3:0]  i_timer_out,
    input  wire [3:0]  i_pin_in,
    // low pin drive, bit 0 is pin 0
    output reg  [3:0]  o_pin_out,
    output reg  [3:0]  o_pin_oe,
    // timer input routing
    output reg  [3:0]  o_capture_sel,
    output reg  [3:0]  o_capture_in,
    output reg         o_ext_clk_e_sel,
    output reg         o_ext_clk_e,
    output reg         o_ext_clk_f_sel,
    output reg         o_ext_clk_f,
    // pull-up control for all eight port b pins
    output reg  [7:0]  o_pullup_on
);
    // control registers
    reg        expansion_enable_q;
    reg [7:0]  dir_q;
    reg [7:0]  pcr_q;
    reg [5:0]  tmode_q;
    reg [15:0] ioctl_q;
    reg [5:0]  tctrl_q;
    reg [16:0] tpresc_q;
    reg [3:0]  pdata_q;
    // bus state
    reg        aw_q;
    reg        w_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    reg        rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0]  rresp_q;
    reg [31:0] rd_d;
    reg        rd_ok;

    // byte-lane merge of a write into an existing word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
            end
        end
    endfunction

    // mode classes
    wire mode_addr   = (i_op_mode == `PBM_MODE_1) || (i_op_mode == `PBM_MODE_2);
    wire mode_47     = (i_op_mode == `PBM_MODE_4) || (i_op_mode == `PBM_MODE_7);
    wire mode_exp    = mode_47 && ((i_op_mode == `PBM_MODE_4) || expansion_enable_q);
    wire mode_single = (i_op_mode == `PBM_MODE_7) && !expansion_enable_q;

    // per-pin decode, pins a..d share one selector module
    wire [3:0] md   = tmode_q[`PBM_F_MD];
    wire [2:0] cclr = tctrl_q[`PBM_F_CCLR];
    wire       buf_on = tmode_q[`PBM_F_BFA] || tmode_q[`PBM_F_BFB];
    wire [1:0] fn_a;
    wire [1:0] fn_b;
    wire [1:0] fn_c;
    wire [1:0] fn_d;
    wire [3:0] cap;
    wire       pwm1_a;
    wire       pwm1_c;

    pbm_pin_sel #(.HAS_PWM1(1), .CCLR_OWN(`PBM_CCLR_A)) u_pin_a (
        .i_mode_addr(mode_addr), .i_mode_exp(mode_exp), .i_mode_single(mode_single),
        .i_dir(dir_q[0]), .i_md(md), .i_io(ioctl_q[3:0]), .i_cclr(cclr),
        .i_pwm1_block(1'b0), .o_func(fn_a), .o_capture(cap[0]), .o_pwm1(pwm1_a));
    // pin b timer output is given up whenever the timer mode field selects pwm mode 1
    pbm_pin_sel #(.HAS_PWM1(0), .CCLR_OWN(`PBM_CCLR_B)) u_pin_b (
        .i_mode_addr(mode_addr), .i_mode_exp(mode_exp), .i_mode_single(mode_single),
        .i_dir(dir_q[1]), .i_md(md), .i_io(ioctl_q[7:4]), .i_cclr(cclr),
        .i_pwm1_block(1'b0), .o_func(fn_b), .o_capture(cap[1]), .o_pwm1());
    // buffer modes take pwm mode 1 away from pin c
    pbm_pin_sel #(.HAS_PWM1(1), .CCLR_OWN(`PBM_CCLR_C)) u_pin_c (
        .i_mode_addr(mode_addr), .i_mode_exp(mode_exp), .i_mode_single(mode_single),
        .i_dir(dir_q[2]), .i_md(md), .i_io(ioctl_q[11:8]), .i_cclr(cclr),
        .i_pwm1_block(buf_on), .o_func(fn_c), .o_capture(cap[2]),
        .o_pwm1(pwm1_c));
    pbm_pin_sel #(.HAS_PWM1(0), .CCLR_OWN(`PBM_CCLR_D)) u_pin_d (
        .i_mode_addr(mode_addr), .i_mode_exp(mode_exp), .i_mode_single(mode_single),
        .i_dir(dir_q[3]), .i_md(md), .i_io(ioctl_q[15:12]), .i_cclr(cclr),
        .i_pwm1_block(1'b0), .o_func(fn_d), .o_capture(cap[3]), .o_pwm1());
    wire [7:0] fn = {fn_d, fn_c, fn_b, fn_a};

    // external clock selection over the prescalers of channels 6..11
    wire phase_cnt = tpresc_q[`PBM_F_PHC7] || tpresc_q[`PBM_F_PHC11];
    wire clk_f_sel = (tctrl_q[`PBM_F_PSC] == `PBM_PSC_CLK_F)
                  || (tpresc_q[`PBM_F_PSC7] == `PBM_PSC_CLK_F)
                  || (tpresc_q[`PBM_F_PSC8] == `PBM_PSC_CLK_F)
                  || phase_cnt;
    wire clk_e_sel = (tctrl_q[`PBM_F_PSC] == `PBM_PSC_CLK_E)
                  || (tpresc_q[`PBM_F_PSC7] == `PBM_PSC_CLK_E)
                  || (tpresc_q[`PBM_F_PSC8] == `PBM_PSC_CLK_E)
                  || (tpresc_q[`PBM_F_PSC9] == `PBM_PSC_CLK_E)
                  || (tpresc_q[`PBM_F_PSC10] == `PBM_PSC_CLK_E)
                  || (tpresc_q[`PBM_F_PSC11] == `PBM_PSC_CLK_E)
                  || phase_cnt;

    // input port state: low pins by decoded function, high pins by direction
    wire [7:0] in_state;
    assign in_state[0] = (fn_a == `PBM_FN_INPUT);
    assign in_state[1] = (fn_b == `PBM_FN_INPUT);
    assign in_state[2] = (fn_c == `PBM_FN_INPUT);
    assign in_state[3] = (fn_d == `PBM_FN_INPUT);
    assign in_state[7:4] = ~dir_q[7:4];
    // hardware standby and modes other than 4,7 force all pull-ups off
    wire [7:0] pullup_d = (mode_47 && !i_hw_standby) ?
                          (in_state & ~dir_q & pcr_q) : 8'h00;

    // pin drive mux, registered so the pads see no decode glitches
    integer p;
    reg [3:0] pin_out_d;
    reg [3:0] pin_oe_d;
    always @* begin
        pin_out_d = 4'h0;
        pin_oe_d  = 4'h0;
        for (p = 0; p < 4; p = p + 1) begin
            if (fn[p*2 +: 2] == `PBM_FN_ADDR) begin
                pin_out_d[p] = i_addr_hi[p];
                pin_oe_d[p]  = 1'b1;
            end else if (fn[p*2 +: 2] == `PBM_FN_TIMER) begin
                pin_out_d[p] = i_timer_out[p];
                pin_oe_d[p]  = 1'b1;
            end else if (fn[p*2 +: 2] == `PBM_FN_PORT) begin
                pin_out_d[p] = pdata_q[p];
                pin_oe_d[p]  = 1'b1;
            end
        end
    end

    // pad and timer-input outputs; reset leaves every pull-up off
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin_out       <= 4'h0;
            o_pin_oe        <= 4'h0;
            o_capture_sel   <= 4'h0;
            o_capture_in    <= 4'h0;
            o_ext_clk_e_sel <= 1'b0;
            o_ext_clk_e     <= 1'b0;
            o_ext_clk_f_sel <= 1'b0;
            o_ext_clk_f     <= 1'b0;
            o_pullup_on     <= 8'h00;
        end else if (i_ce) begin
            o_pin_out       <= pin_out_d;
            o_pin_oe        <= pin_oe_d;
            o_capture_sel   <= mode_single ? cap : 4'h0;
            o_capture_in    <= mode_single ? (cap & i_pin_in) : 4'h0;
            o_ext_clk_e_sel <= mode_single && clk_e_sel;
            o_ext_clk_e     <= mode_single && clk_e_sel && i_pin_in[2];
            o_ext_clk_f_sel <= mode_single && clk_f_sel;
            o_ext_clk_f     <= mode_single && clk_f_sel && i_pin_in[3];
            o_pullup_on     <= pullup_d;
        end
    end

    // axi handshakes: one beat per channel per write; none while frozen
    assign o_awready = i_ce && !aw_q && !bvalid_q;
    assign o_wready  = i_ce && !w_q && !bvalid_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_arready = i_ce && !rvalid_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    wire [3:0] wr_idx = awaddr_q[`PBM_IDX_MSB:`PBM_IDX_LSB];
    wire       wr_hit = (awaddr_q[31:`PBM_IDX_MSB+1] == 26'h000_0000)
                        && (wr_idx <= `PBM_OFS_PDATA);
    wire [31:0] wm_ctrl = merge({31'h0000_0000, expansion_enable_q}, wdata_q, wstrb_q);
    wire [31:0] wm_dir  = merge({24'h00_0000, dir_q}, wdata_q, wstrb_q);
    wire [31:0] wm_pcr  = merge({24'h00_0000, pcr_q}, wdata_q, wstrb_q);
    wire [31:0] wm_tm   = merge({26'h000_0000, tmode_q}, wdata_q, wstrb_q);
    wire [31:0] wm_io   = merge({16'h0000, ioctl_q}, wdata_q, wstrb_q);
    wire [31:0] wm_tc   = merge({26'h000_0000, tctrl_q}, wdata_q, wstrb_q);
    wire [31:0] wm_ps   = merge({15'h0000, tpresc_q}, wdata_q, wstrb_q);
    wire [31:0] wm_pd   = merge({28'h000_0000, pdata_q}, wdata_q, wstrb_q);

    // write path: latch address and data in any order, then commit once
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= `PBM_ZERO32;
            wdata_q  <= `PBM_ZERO32;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= `PBM_RESP_OKAY;
            expansion_enable_q   <= `PBM_RST_CTRL;
            dir_q    <= `PBM_RST_DIR;
            pcr_q    <= `PBM_RST_PULLUP;
            tmode_q  <= `PBM_RST_TMODE6;
            ioctl_q  <= `PBM_RST_IOCTL6;
            tctrl_q  <= `PBM_RST_TCTRL6;
            tpresc_q <= `PBM_RST_TPRESC;
            pdata_q  <= `PBM_RST_PDATA;
        end else if (i_ce) begin
            if (i_awvalid && o_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_q     <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (aw_q && w_q && !bvalid_q) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
                if (!wr_hit) begin
                    bresp_q <= `PBM_RESP_SLVERR;
                end else if (wr_idx == `PBM_OFS_CTRL) begin
                    expansion_enable_q <= wm_ctrl[0];
                end else if (wr_idx == `PBM_OFS_DIR) begin
                    dir_q <= wm_dir[7:0];
                end else if (wr_idx == `PBM_OFS_PULLUP) begin
                    pcr_q <= wm_pcr[7:0];
                end else if (wr_idx == `PBM_OFS_TMODE6) begin
                    tmode_q <= wm_tm[5:0];
                end else if (wr_idx == `PBM_OFS_IOCTL6) begin
                    ioctl_q <= wm_io[15:0];
                end else if (wr_idx == `PBM_OFS_TCTRL6) begin
                    tctrl_q <= wm_tc[5:0];
                end else if (wr_idx == `PBM_OFS_TPRESC) begin
                    tpresc_q <= wm_ps[16:0];
                end else if (wr_idx == `PBM_OFS_PDATA) begin
                    pdata_q <= wm_pd[3:0];
                end
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read decode; status is read-only, port data reads pins where input
    wire [3:0] rd_idx = i_araddr[`PBM_IDX_MSB:`PBM_IDX_LSB];
    wire       rd_top = (i_araddr[31:`PBM_IDX_MSB+1] == 26'h000_0000);
    always @* begin
        rd_d  = `PBM_ZERO32;
        rd_ok = rd_top;
        if (!rd_top) begin
            rd_ok = 1'b0;
        end else if (rd_idx == `PBM_OFS_CTRL) begin
            rd_d = {29'h0000_0000, i_op_mode[2:1], expansion_enable_q};
        end else if (rd_idx == `PBM_OFS_DIR) begin
            rd_d = {24'h00_0000, dir_q};
        end else if (rd_idx == `PBM_OFS_PULLUP) begin
            rd_d = {24'h00_0000, pcr_q};
        end else if (rd_idx == `PBM_OFS_TMODE6) begin
            rd_d = {26'h000_0000, tmode_q};
        end else if (rd_idx == `PBM_OFS_IOCTL6) begin
            rd_d = {16'h0000, ioctl_q};
        end else if (rd_idx == `PBM_OFS_TCTRL6) begin
            rd_d = {26'h000_0000, tctrl_q};
        end else if (rd_idx == `PBM_OFS_TPRESC) begin
            rd_d = {15'h0000, tpresc_q};
        end else if (rd_idx == `PBM_OFS_PDATA) begin
            rd_d = {28'h000_0000, (dir_q[3:0] & pdata_q) | (~dir_q[3:0] & i_pin_in)};
        end else if (rd_idx == `PBM_OFS_STATUS) begin
            rd_d = {8'h00, pwm1_c, pwm1_a, o_ext_clk_f_sel, o_ext_clk_e_sel,
                    o_capture_sel, o_pullup_on, fn};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // read path: one outstanding read, data held until rready
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= `PBM_ZERO32;
            rresp_q  <= `PBM_RESP_OKAY;
        end else if (i_ce) begin
            if (i_arvalid && o_arready) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_d;
                rresp_q  <= rd_ok ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
            end else if (rvalid_q && i_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule // pbm_top

// ===== tb/pbm_top_properties.sv
// assertion checker for the port b low pin selector
`timescale 1ns/1ns
module pbm_chk (
    // clock, reset, enable
    input wire        i_clk,
    input wire        i_nrst,
    input wire        i_ce,
    // chip state and pin sources
    input wire [2:0]  i_op_mode,
    input wire        i_hw_standby,
    input wire [3:0]  i_addr_hi,
    input wire [3:0]  i_pin_in,
    // bus handshakes
    input wire        i_arvalid,
    input wire        o_arready,
    input wire        o_rvalid,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire [1:0]  o_bresp,
    // pin side outputs
    input wire [3:0]  o_pin_out,
    input wire [3:0]  o_pin_oe,
    input wire [3:0]  o_capture_sel,
    input wire [3:0]  o_capture_in,
    input wire        o_ext_clk_e_sel,
    input wire        o_ext_clk_e,
    input wire [7:0]  o_pullup_on
);
    // the decode is registered, so each cause sits one edge back
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    chk_addr_drive:
        assert property ($past(i_nrst) && $past(i_ce) && $past(i_op_mode) inside {3'h1, 3'h2}
            |-> o_pin_oe == 4'hf && o_pin_out == $past(i_addr_hi)) else $error("address drive");
    chk_pullup_addr:
        assert property ($past(i_nrst) && $past(i_ce) && $past(i_op_mode) inside {3'h1, 3'h2}
            |-> o_pullup_on == 8'h00) else $error("pull-up in address mode");
    chk_pullup_stby:
        assert property ($past(i_nrst) && $past(i_ce) && $past(i_hw_standby)
            |-> o_pullup_on == 8'h00) else $error("pull-up in standby");
    chk_bad_mode:
        assert property ($past(i_nrst) && $past(i_ce)
            && !($past(i_op_mode) inside {3'h1, 3'h2, 3'h4, 3'h7})
            |-> o_pin_oe == 4'h0 && o_pullup_on == 8'h00) else $error("unknown mode pins");
    chk_capture_data:
        assert property ($past(i_nrst) && $past(i_ce)
            |-> o_capture_in == (o_capture_sel & $past(i_pin_in))) else $error("capture path");
    chk_clk_e_data:
        assert property ($past(i_nrst) && $past(i_ce)
            |-> o_ext_clk_e == (o_ext_clk_e_sel & $past(i_pin_in[2]))) else $error("clock e path");
    chk_read_answer:
        assert property (i_arvalid && o_arready && i_ce |=> o_rvalid) else $error("read late");
    chk_bresp_hold:
        assert property (o_bvalid && !i_bready && i_ce |=> o_bvalid && $stable(o_bresp))
            else $error("write response dropped");
endmodule // pbm_chk

bind pbm_top pbm_chk u_pbm_chk (
    .i_clk, .i_nrst, .i_ce, .i_op_mode, .i_hw_standby, .i_addr_hi, .i_pin_in, .i_arvalid,
    .o_arready, .o_rvalid, .o_bvalid, .i_bready, .o_bresp, .o_pin_out, .o_pin_oe,
    .o_capture_sel, .o_capture_in, .o_ext_clk_e_sel, .o_ext_clk_e, .o_pullup_on
);

// ===== tb/testbench.sv
// self-checking bench for the port b low pin selector
`timescale 1ns/1ns
module testbench;
    typedef struct {string nm; logic [33:0] ex; logic [33:0] mk;} pbm_note_t;
    // stimulus, shadow settings and bookkeeping
    logic        i_clk = 0, i_nrst = 0, i_ce = 1, hs = 0, ex = 0, bfa = 0, bfb = 0;
    logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pin_chk = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0;
    logic [2:0]  mode = 3'h7, m, cclr = 0, psc6 = 0;
    logic [3:0]  ah = 0, tmo = 0, pin = 0, md = 0, pd = 0;
    logic [7:0]  dir = 0, pu = 0;
    logic [15:0] io = 0;
    logic [16:0] tp = 0;
    logic [2:0]  modes [8] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h7, 3'h7, 3'h0, 3'h5};
    wire         awr, wrr, bv, arr, rv, ckf;
    wire  [1:0]  br, rr;
    wire  [31:0] rdat;
    wire  [3:0]  po, poe;
    pbm_note_t   q[$];
    int          fails = 0, tests_run = 0;

    pbm_top u_pbm_top (
        .i_clk, .i_nrst, .i_ce, .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
        .i_awprot(3'h0), .i_wvalid(wv), .o_wready(wrr), .i_wdata(wd), .i_wstrb(4'hf),
        .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
        .i_araddr(ara), .i_arprot(3'h0), .o_rvalid(rv), .i_rready(rry), .o_rdata(rdat),
        .o_rresp(rr), .i_op_mode(mode), .i_hw_standby(hs), .i_addr_hi(ah),
        .i_timer_out(tmo), .i_pin_in(pin), .o_pin_out(po), .o_pin_oe(poe),
        .o_capture_sel(), .o_capture_in(), .o_ext_clk_e_sel(), .o_ext_clk_e(),
        .o_ext_clk_f_sel(), .o_ext_clk_f(ckf), .o_pullup_on()
    );

    always #4 i_clk = ~i_clk;

    // print the counts and the verdict, then stop
    task automatic test_done();
        $display("checks run %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // one write; both channels offered together, ready raised late at random to stall
    task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] rsp = 2'h0);
        logic ta, tw;
        q.push_back('{"bresp", {32'h0, rsp}, 34'h3});
        @(posedge i_clk);
        awv <= 1;
        awa <= a;
        wv <= 1;
        wd <= d;
        ta = 0;
        tw = 0;
        while (!(ta && tw)) begin
            @(posedge i_clk);
            ta = ta | awr;
            tw = tw | wrr;
            awv <= !ta;
            wv <= !tw;
        end
        repeat ($urandom % 3) @(posedge i_clk);
        bry <= 1;
        do @(posedge i_clk); while (!bv);
        bry <= 0;
    endtask

    // one read; the monitor judges data and response
    task automatic rd(logic [31:0] a, logic [31:0] e, logic [31:0] mk = 32'hffff_ffff,
                      logic [1:0] rsp = 2'h0);
        q.push_back('{"rdata", {rsp, e}, {2'h3, mk}});
        @(posedge i_clk);
        arv <= 1;
        ara <= a;
        do @(posedge i_clk); while (!arr);
        arv <= 0;
        repeat ($urandom % 3) @(posedge i_clk);
        rry <= 1;
        do @(posedge i_clk); while (!rv);
        rry <= 0;
    endtask

    // compare a result with the oldest note; a result with no note always fails
    task automatic cmp(logic [33:0] got);
        pbm_note_t n;
        n = '{"extra", 'x, '1};
        if (q.size() != 0) n = q.pop_front();
        tests_run++;
        if ((got & n.mk) !== (n.ex & n.mk)) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n.nm, n.ex & n.mk, got & n.mk);
        end
    endtask

    // one compare per kind of result: write response, read answer, pin state
    task automatic cmp_b(logic [1:0] g);
        cmp({32'h0, g});
    endtask
    task automatic cmp_r(logic [33:0] g);
        cmp(g);
    endtask
    task automatic cmp_p(logic [8:0] g);
        cmp({25'h0, g});
    endtask

    always @(posedge i_clk) begin
        if (bv && bry) cmp_b(br);
        if (rv && rry) cmp_r({rr, rdat});
        if (pin_chk) cmp_p({ckf, poe, po});
    end

    // expected function of low pin k: 0 input, 1 address, 2 port out, 3 timer
    function automatic logic [1:0] fn(int k);
        logic [3:0] f;
        logic       t;
        f = io[4*k +: 4];
        t = md == 4'h0 ? !f[3] && f[1:0] != 0 :
            md == 4'h2 ? !k[0] && f[1:0] != 0 && !(k == 2 && (bfa || bfb)) :
            md == 4'h3 && f[1:0] != 0 && cclr != (k < 2 ? k + 1 : k + 3);
        if (mode == 3'h1 || mode == 3'h2) return 2'h1;
        if (mode == 3'h4 || (mode == 3'h7 && ex)) return {1'b0, dir[k]};
        if (mode != 3'h7) return 2'h0;
        return t ? 2'h3 : {dir[k], 1'b0};
    endfunction

    // settle, then check pins, status and readback against the shadow settings
    task automatic check_all();
        logic [23:0] st;
        logic [3:0]  oe, ov;
        logic        s7;
        s7 = mode == 3'h7 && !ex;
        for (int k = 0; k < 8; k++)
            st[8+k] = mode[2] && mode[1:0] != 2'h1 && !hs && pu[k]
                      && (k < 4 ? fn(k) == 2'h0 : !dir[k]);
        for (int k = 0; k < 4; k++) begin
            st[2*k +: 2] = fn(k);
            st[16+k] = s7 && md == 4'h0 && io[4*k+2 +: 2] == 2'h2;
            oe[k] = fn(k) != 2'h0;
            ov[k] = fn(k) == 2'h1 ? ah[k] : fn(k) == 2'h2 ? pd[k] : tmo[k];
        end
        st[20] = s7 && (psc6 == 4 || tp[2:0] == 4 || tp[5:3] == 4 || tp[8:6] == 4
                 || tp[11:9] == 4 || tp[14:12] == 4 || tp[15] || tp[16]);
        st[21] = s7 && (psc6 == 5 || tp[2:0] == 5 || tp[5:3] == 5 || tp[15] || tp[16]);
        st[22] = md == 4'h2 && io[1:0] != 0;
        st[23] = md == 4'h2 && io[9:8] != 0 && !(bfa || bfb);
        repeat (3) @(posedge i_clk);
        q.push_back('{"pins", {25'h0, st[21] & pin[3], oe, ov},
                      {25'h0, 1'b1, 4'hf, oe}});
        pin_chk <= 1;
        @(posedge i_clk);
        pin_chk <= 0;
        rd(32'h20, st, 32'hff_ffff);
        rd(32'h00, {mode[2:1], ex});
        rd(32'h04, dir);
        rd(32'h1c, (dir[3:0] & pd) | (~dir[3:0] & pin));
    endtask

    // reset, bad addresses, then random settings across modes 0, 1, 2, 4, 5, 7 and every timer mode
    initial begin
        void'($urandom(32'h0652));
        repeat (2) @(posedge i_clk);
        i_nrst <= 1;
        check_all();
        wr(32'h24, 32'h1, 2'h2);
        wr(32'h20, 32'h1, 2'h2);
        rd(32'h24, 32'h0, 32'hffff_ffff, 2'h2);
        for (int i = 0; i < 200; i++) begin
            m = modes[$urandom % 8];
            mode <= m;
            ex = m == 3'h4 || $urandom % 2;
            hs <= $urandom % 8 == 0;
            ah <= $urandom;
            tmo <= $urandom;
            pin <= $urandom;
            dir = $urandom;
            pu = $urandom;
            md = ($urandom % 3 * 3 + 1) / 2;
            bfa = $urandom % 4 == 0;
            bfb = $urandom % 4 == 0;
            io = $urandom;
            cclr = $urandom;
            psc6 = $urandom;
            tp = {$urandom % 8 == 0, $urandom % 8 == 0, 15'($urandom)};
            pd = $urandom;
            wr(32'h00, ex);
            wr(32'h04, dir);
            wr(32'h08, pu);
            wr(32'h0c, {bfb, bfa, md});
            wr(32'h10, io);
            wr(32'h14, {cclr, psc6});
            wr(32'h18, tp);
            wr(32'h1c, pd);
            check_all();
        end
        test_done();
    end

    // cut a hang short well past the expected run length
    initial begin
        #(8 * 60000);
        fails++;
        test_done();
    end
endmodule // testbench
